// ---- hdl/dic_top.sv ----
// Purpose: Digital input conditioner: scan, polarity, delays, routing.
// Assumes: Field inputs are asynchronous; settings are static-ish levels.
// Notes: Internal and output views are re-registered on scan ticks.
`timescale 1ns/1ps
// Operation
// - Sample every input once per 5 ms scan.
// - Per-channel polarity, normally open by default.
// - Rising change waits the activation delay.
// - Falling change waits the drop-off delay.
// - AC option adds 30 ms before deactivation.
// - Internal consumers see one more scan.
// - Direct output route adds one more scan.
module dic_top
  import dic_pkg::*;
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned SCAN_CYC = DIC_SCAN_CYC,
  parameter int unsigned STEP_CYC = DIC_STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [CHANNELS-1:0] digital_input_channel,
  input wire logic [CHANNELS-1:0] polarity_closed,
  input wire logic [CHANNELS-1:0] alternating_supply_hold,
  input wire logic [CHANNELS*DIC_DELAY_W-1:0] pickup_delay,
  input wire logic [CHANNELS*DIC_DELAY_W-1:0] dropoff_delay,
  output logic [CHANNELS-1:0] input_status,
  output logic [CHANNELS-1:0] logic_status,
  output logic [CHANNELS-1:0] digital_output_channels
);
  localparam int SCW = $clog2(SCAN_CYC);
  localparam int STW = $clog2(STEP_CYC);
  dic_tick_if tick ();
  logic [CHANNELS-1:0] sync_a;
  logic [CHANNELS-1:0] sync_b;
  logic [CHANNELS-1:0] qual;
  logic [CHANNELS-1:0] logic_stage;
  logic [SCW-1:0] scan_cnt;
  logic [STW-1:0] step_cnt;
  logic scan_pulse;
  logic step_pulse;
  wire logic scan_wrap = scan_cnt == SCW'(SCAN_CYC - 1);
  wire logic step_wrap = step_cnt == STW'(STEP_CYC - 1);
  // Polarity: energized reads 1 when open, 0 when closed
  wire logic [CHANNELS-1:0] polar = sync_b ^ polarity_closed;

  assign tick.scan_tick = scan_pulse;
  assign tick.step_tick = step_pulse;

  ////////////////////////////////////////////////////////////////////
  // Scan and step dividers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scan_cnt <= '0;
      step_cnt <= '0;
      scan_pulse <= 1'b0;
      step_pulse <= 1'b0;
    end else begin
      scan_cnt <= scan_wrap ? '0 : scan_cnt + 1'b1;
      step_cnt <= step_wrap ? '0 : step_cnt + 1'b1;
      scan_pulse <= scan_wrap;
      step_pulse <= step_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= digital_input_channel;
      sync_b <= sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Channel qualifiers
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    dic_chan u_chan (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick.dst),
      .raw_state(polar[i]),
      .pickup_delay(pickup_delay[i*DIC_DELAY_W +: DIC_DELAY_W]),
      .dropoff_delay(dropoff_delay[i*DIC_DELAY_W +: DIC_DELAY_W]),
      .alternating_supply_hold(alternating_supply_hold[i]),
      .qual_state(qual[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Per-clock status register and scan-cycle pipeline to consumers and outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input_status <= '0;
      logic_stage <= '0;
      logic_status <= '0;
      digital_output_channels <= '0;
    end else begin
      input_status <= qual;
      if (scan_pulse) begin
        logic_stage <= qual;
        logic_status <= qual;
        digital_output_channels <= logic_stage;
      end
    end
  end
endmodule // dic_top

// ---- hdl/dic_pkg.sv ----
// Purpose: Shared constants and types for the digital input conditioner.
// Assumes: 50 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package dic_pkg;
  localparam int unsigned DIC_CLK_HZ = 50_000_000;
  localparam int unsigned DIC_SCAN_MS = 5;
  localparam int unsigned DIC_STEP_US = 1000;
  localparam int unsigned DIC_AC_HOLD_MS = 30;
  localparam int unsigned DIC_SCAN_CYC = DIC_CLK_HZ / 1000 * DIC_SCAN_MS;
  localparam int unsigned DIC_STEP_CYC = DIC_CLK_HZ / 1_000_000 * DIC_STEP_US;
  localparam int unsigned DIC_AC_HOLD_STEPS = DIC_AC_HOLD_MS * 1000 / DIC_STEP_US;
  localparam int unsigned DIC_DELAY_W = 21;
  localparam logic [DIC_DELAY_W-1:0] DIC_DELAY_MAX = 21'h1b7740;
  localparam logic [DIC_DELAY_W-1:0] DIC_DELAY_RST = 21'h000000;
  localparam logic DIC_POL_NO = 1'b0;
  localparam logic DIC_AC_RST = 1'b0;
  typedef logic [DIC_DELAY_W-1:0] dic_delay_t;
  typedef enum logic [1:0] {
    DIC_IDLE = 2'b00,
    DIC_RISE = 2'b01,
    DIC_FALL = 2'b10
  } dic_state_t;
endpackage

// ---- hdl/dic_tick_if.sv ----
// Purpose: Carries the shared timebase enables to the channel qualifier.
// Assumes: Driven by the top, one clock domain.
// Notes: Both enables are one-cycle pulses.
`timescale 1ns/1ps
interface dic_tick_if;
  logic scan_tick;
  logic step_tick;
  modport src (output scan_tick, output step_tick);
  modport dst (input scan_tick, input step_tick);
endinterface

// ---- hdl/dic_chan.sv ----
// Purpose: Qualifies one digital input channel with pick-up and drop-off delays.
// Assumes: Input is already synchronised and polarity applied.
// Notes: Delays count in 1 ms steps; AC hold extends the drop-off.
`timescale 1ns/1ps
module dic_chan
  import dic_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  dic_tick_if.dst tick,
  input wire logic raw_state,
  input wire dic_pkg::dic_delay_t pickup_delay,
  input wire dic_pkg::dic_delay_t dropoff_delay,
  input wire logic alternating_supply_hold,
  output logic qual_state
);
  dic_state_t state;
  dic_delay_t count;
  logic [DIC_DELAY_W:0] drop_total;
  logic sampled;
  wire logic differs = sampled != qual_state;
  wire logic rise_done = (count >= pickup_delay);
  wire logic fall_done = ({1'b0, count} >= drop_total);

  // Total drop-off including the AC hold
  always_comb begin
    drop_total = {1'b0, dropoff_delay};
    if (alternating_supply_hold) begin
      drop_total = {1'b0, dropoff_delay} + (DIC_DELAY_W+1)'(DIC_AC_HOLD_STEPS);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Scan sampling and delay qualification
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampled <= 1'b0;
      qual_state <= 1'b0;
      count <= DIC_DELAY_RST;
      state <= DIC_IDLE;
    end else begin
      if (tick.scan_tick) begin
        sampled <= raw_state;
      end
      case (state)
        DIC_IDLE: begin
          count <= DIC_DELAY_RST;
          if (differs) begin
            state <= qual_state ? DIC_FALL : DIC_RISE;
          end
        end
        DIC_RISE: begin
          if (!differs) begin
            state <= DIC_IDLE;
            count <= DIC_DELAY_RST;
          end else if (rise_done) begin
            qual_state <= 1'b1;
            state <= DIC_IDLE;
          end else if (tick.step_tick) begin
            count <= count + 1'b1;
          end
        end
        DIC_FALL: begin
          if (!differs) begin
            state <= DIC_IDLE;
            count <= DIC_DELAY_RST;
          end else if (fall_done) begin
            qual_state <= 1'b0;
            state <= DIC_IDLE;
          end else if (tick.step_tick) begin
            count <= count + 1'b1;
          end
        end
        default: begin
          state <= DIC_IDLE;
        end
      endcase
    end
  end
endmodule // dic_chan

// ---- dv/dic_top_props.sv ----
// Purpose: Port timing checks for the input conditioner.
// Assumes: One clock, sync reset; channel 0 is timed.
// Notes: Timer steps allow one step of slack early and two late.
`timescale 1ns/1ps
module dic_top_props
  import dic_pkg::*;
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned SCAN_CYC = 20,
  parameter int unsigned STEP_CYC = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [CHANNELS-1:0] digital_input_channel,
  input wire logic [CHANNELS-1:0] polarity_closed,
  input wire logic [CHANNELS-1:0] alternating_supply_hold,
  input wire logic [CHANNELS*DIC_DELAY_W-1:0] pickup_delay,
  input wire logic [CHANNELS*DIC_DELAY_W-1:0] dropoff_delay,
  input wire logic [CHANNELS-1:0] input_status,
  input wire logic [CHANNELS-1:0] logic_status,
  input wire logic [CHANNELS-1:0] digital_output_channels
);
  int hi, lo, ph, rise_t, fall_t;
  logic seen;
  wire eff = digital_input_channel[0] ^ polarity_closed[0];
  // Delay targets in clocks
  assign rise_t = int'(pickup_delay[DIC_DELAY_W-1:0]) * STEP_CYC;
  assign fall_t = (int'(dropoff_delay[DIC_DELAY_W-1:0])
    + (alternating_supply_hold[0] ? DIC_AC_HOLD_STEPS : 0)) * STEP_CYC;
  // Stable-time counters and scan phase since the last view change
  always_ff @(posedge clk) begin
    hi <= (sys_rst || !eff) ? 0 : hi + 1;
    lo <= (sys_rst || eff) ? 0 : lo + 1;
    seen <= !sys_rst && (seen || $changed(logic_status));
    ph <= (sys_rst || $changed(logic_status) || $changed(digital_output_channels)) ? 1 :
      (ph == SCAN_CYC - 1) ? 0 : ph + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_zero: assert property ($fell(sys_rst) |-> (input_status | logic_status |
    digital_output_channels) == 0) else $error("outputs not clear after reset");
  a_scan_aligned: assert property (seen && ($changed(logic_status) ||
    $changed(digital_output_channels)) |-> ph == 0) else $error("view off scan");
  // The status view and the logic view both take the qualified state of the same edge
  a_logic_follow: assert property ($changed(logic_status) |->
    logic_status == input_status) else $error("logic view wrong");
  a_out_follow: assert property ($changed(digital_output_channels) |->
    digital_output_channels == $past(logic_status)) else $error("output view wrong");
  a_rise_early: assert property ($rose(input_status[0]) |->
    hi >= 3 && hi + STEP_CYC > rise_t) else $error("rise too early");
  a_fall_early: assert property ($fell(input_status[0]) |->
    lo >= 3 && lo + STEP_CYC > fall_t) else $error("fall too early");
  a_rise_late: assert property (hi == rise_t + 2 * STEP_CYC + SCAN_CYC + 8 |->
    input_status[0]) else $error("rise too late");
  a_fall_late: assert property (lo == fall_t + 2 * STEP_CYC + SCAN_CYC + 8 |->
    !input_status[0]) else $error("fall too late");
endmodule // dic_top_props

// ---- dv/dic_field.sv ----
// Purpose: Field contacts energising the input pins.
// Assumes: Contact state is commanded by the bench.
// Notes: One clock of lag models the contact closing.
`timescale 1ns/1ps
module dic_field (
  input wire logic clk,
  input wire logic [7:0] close_req,
  output logic [7:0] digital_input_channel
);
  // Contacts follow the command
  always_ff @(posedge clk) begin
    digital_input_channel <= close_req;
  end
endmodule // dic_field

// ---- dv/dic_top_bench.sv ----
// Purpose: Self-checking bench for the input conditioner.
// Assumes: Short scan and step counts.
// Notes: Waits are bounds on the documented latencies.
`timescale 1ns/1ps
module dic_top_bench;
  import dic_pkg::*;
  localparam int S = 20;
  localparam int P = 4;
  localparam int W = 3 * S + 3 * P + 10;
  logic clk = 0;
  logic sys_rst = 1;
  logic [7:0] close_req = 0, polarity_closed = 0, alternating_supply_hold = 0;
  logic [167:0] pickup_delay = 0, dropoff_delay = 0;
  logic [7:0] digital_input_channel, input_status, logic_status, digital_output_channels;
  int n_mismatch = 0;
  int check_count = 0;
  initial forever #10 clk = ~clk;
  dic_field dic_field_i (.clk, .close_req, .digital_input_channel);
  dic_top #(.SCAN_CYC(S), .STEP_CYC(P)) dic_top_i (.clk, .sys_rst, .digital_input_channel,
    .polarity_closed, .alternating_supply_hold, .pickup_delay, .dropoff_delay,
    .input_status, .logic_status, .digital_output_channels);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
  // Main sequence
  initial begin
    cyc(8);
    sys_rst <= 0;
    cyc(2);
    chk("input", input_status, 8'h00);
    polarity_closed <= 8'hf0;
    cyc(W);
    chk("output", digital_output_channels, 8'hf0);
    close_req <= 8'hff;
    cyc(W);
    chk("logic", logic_status, 8'h0f);
    chk("output", digital_output_channels, 8'h0f);
    polarity_closed <= 8'h00;
    close_req <= 8'h00;
    cyc(W);
    chk("input", input_status, 8'h00);
    pickup_delay <= 168'h14;
    dropoff_delay <= 168'h2;
    alternating_supply_hold <= 8'h01;
    close_req <= 8'h01;
    cyc(S);
    close_req <= 8'h00;
    cyc(30 * P);
    chk("glitch", input_status, 8'h00);
    close_req <= 8'h01;
    cyc(19 * P);
    chk("pickup early", input_status, 8'h00);
    cyc(4 * P + S + 10);
    chk("pickup", input_status, 8'h01);
    close_req <= 8'h00;
    cyc(30 * P);
    chk("ac hold", input_status, 8'h01);
    cyc(5 * P + S + 10);
    chk("dropoff", input_status, 8'h00);
    test_done;
  end
endmodule // dic_top_bench
bind dic_top dic_top_props #(.CHANNELS(CHANNELS), .SCAN_CYC(SCAN_CYC), .STEP_CYC(STEP_CYC))
  dic_top_props_i (.clk, .sys_rst, .digital_input_channel, .polarity_closed,
  .alternating_supply_hold, .pickup_delay, .dropoff_delay, .input_status, .logic_status,
  .digital_output_channels);
